// ===== design/pcm_codec_pkg.sv
/*
 * Shared constants and types for the PCM codec serial port and its far-end controller.
 * Assumes one system clock (aclk, 125 MHz); the 2.048 MHz master clock is made from it.
 */
package pcm_codec_pkg;

    // three-level control address: logic low, negative rail, logic high
    typedef enum logic [1:0] {CA_LOW, CA_NEG, CA_HIGH} ca_level_t;

    ////////////////////////////////////////////////////////////////////////////////
    // word layout
    localparam int PCM_BITS = 8;
    localparam int SIGN_BIT = 7;
    localparam int CHORD_W = 3;
    localparam int STEP_W = 4;
    localparam int CHORDS = 8;
    localparam int MAG_W = 12;
    localparam int CNT_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // control register A fields
    localparam int TXG_LSB = 0;
    localparam int RXG_LSB = 3;
    localparam int GAIN_W = 3;
    localparam int LOOP_BIT = 6;
    localparam int TEST_BIT = 7;
    // control register B fields
    localparam int PP_LSB = 0;
    localparam int PP_W = 3;
    localparam int OD_ANA_BIT = 3;
    localparam int OD_DIG_LSB = 4;
    localparam int OD_DIG_W = 2;
    localparam int PD_BIT = 6;
    localparam logic [7:0] CTL_A_RESET = 8'h00;
    localparam logic [7:0] CTL_B_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 125_000_000;
    localparam int MCLK_HZ = 2_048_000;
    // longest half period rounds down
    localparam int MCLK_HALF = CLK_HZ / (2 * MCLK_HZ);
    localparam int DIV_W = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // controller registers over axi4-lite
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_DRIVE = 8'h0c;
    localparam int CTRL_START = 0;
    localparam int CTRL_CA_LSB = 1;
    localparam int CTRL_LVL = 3;
    localparam int DATA_CTL_LSB = 8;
    localparam int STAT_BUSY = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/codec_link_if.sv
/*
 * Serial link between the codec serial port and the switching-system controller.
 * Assumes the bench instantiates it once and binds the device and host modports.
 */
`timescale 1ns/1ns
interface codec_link_if;
    import pcm_codec_pkg::*;

    logic master_clock_in;
    logic frame_sync_n;
    ca_level_t control_address_select;
    logic control_serial_in;
    logic pcm_serial_in;
    logic pcm_serial_out;
    logic pcm_out_oe;
    logic [2:0] push_pull_drive_outputs;
    logic analog_ground_drain_oe;
    logic [1:0] digital_ground_drain_oe;

    // resolved wire levels; pcm bus has a pull-up, drains pull low when enabled
    logic pcm_bus;
    logic analog_ground_drain_output;
    logic [1:0] digital_ground_drain_outputs;

    assign pcm_bus = pcm_out_oe ? pcm_serial_out : 1'b1;
    assign analog_ground_drain_output = ~analog_ground_drain_oe;
    assign digital_ground_drain_outputs = ~digital_ground_drain_oe;

    modport device (
        input master_clock_in,
        input frame_sync_n,
        input control_address_select,
        input control_serial_in,
        input pcm_serial_in,
        output pcm_serial_out,
        output pcm_out_oe,
        output push_pull_drive_outputs,
        output analog_ground_drain_oe,
        output digital_ground_drain_oe
    );

    modport host (
        output master_clock_in,
        output frame_sync_n,
        output control_address_select,
        output control_serial_in,
        output pcm_serial_in,
        input pcm_bus,
        input push_pull_drive_outputs,
        input analog_ground_drain_output,
        input digital_ground_drain_outputs
    );

endinterface

// ===== design/codec_serial_port.sv
/*
 * Device end: serial port of a telephone voice codec, with encoder front end
 * and the control registers that steer gain, loopback, test, power and drives.
 * Assumes link pins synchronous to aclk and far slower; edges seen against last cycle.
 */
//
// Notes on behaviour
// - control input: steady high, steady low, or word
// - control words steer power, gain, loopback, test, drives
// - one incoming pcm word accepted per frame
// - far end supplies continuous 2.048 mhz master clock
// - pcm output driven only while shifting word
// - frame sync active low, sampled on rising edges
// - shifting only while sync low, qualified by address
// - three-level address: pcm enable and register choice
// - drive outputs three to five are open drain
// - drive outputs zero to two push-pull, low idle
// - one logarithmic eight-bit word per 8 khz frame
// - all internal timing from master clock
// - successive approximation: eight chords, sixteen steps
// - pcm words move bit-serially, eight bits
// - capture on falling edges, launch on rising
// - first rising edge after sync low drives sign
// - sign bit 7 first, chord 6-4, step 3-0
// - sync high after eighth pulse ends transfer
`timescale 1ns/1ns
module codec_serial_port
    import pcm_codec_pkg::*;
#(
    parameter int SAMPLE_W = MAG_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    codec_link_if.device link,
    input wire logic tx_sample_sign,
    input wire logic [SAMPLE_W-1:0] tx_sample_mag,
    output logic [7:0] rx_pcm_word,
    output logic rx_pcm_valid,
    output logic [GAIN_W-1:0] tx_gain,
    output logic [GAIN_W-1:0] rx_gain,
    output logic loopback,
    output logic chip_test,
    output logic power_down
);

    typedef struct packed {
        logic mclk;
        logic armed;
        logic active;
        logic [CNT_W-1:0] cnt;
        ca_level_t ca;
        logic [7:0] tx_sr;
        logic [7:0] rx_sr;
        logic [7:0] ctl_sr;
        logic [7:0] reg_a;
        logic [7:0] reg_b;
        logic steady_pd;
        logic out;
        logic oe;
        logic [7:0] rx_word;
        logic rx_valid;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    logic rise;
    logic fall;

    ////////////////////////////////////////////////////////////////////////////////
    // encoder: leading-one search stands in for the successive approximation
    // ladder; the chord found narrows the step exactly as the ladder would
    function automatic logic [7:0] pcm_encode(input logic sign,
                                              input logic [SAMPLE_W-1:0] mag);
        logic [CHORD_W-1:0] chord;
        logic [STEP_W-1:0] step;
        chord = '0;
        step = mag[STEP_W-1:0];
        for (int c = 1; c < CHORDS; c++) begin
            if (mag[c + STEP_W - 1]) begin
                chord = CHORD_W'(c);
                step = STEP_W'(mag >> (c - 1));
            end
        end
        return {sign, chord, step};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection on the master clock, no other time base
    assign rise = link.master_clock_in & ~q.mclk;
    assign fall = ~link.master_clock_in & q.mclk;

    always_comb begin
        d = q;
        d.mclk = link.master_clock_in;
        d.rx_valid = 1'b0;
        if (rise) begin
            if (link.frame_sync_n) begin
                // sync high ends any transfer and re-arms the next
                d.armed = 1'b1;
                d.active = 1'b0;
                d.oe = 1'b0;
            end else if (q.armed) begin
                d.armed = 1'b0;
                d.active = 1'b1;
                d.cnt = '0;
                d.ca = link.control_address_select;
                // one sample taken per frame, i.e. at 8 khz
                d.tx_sr = q.reg_a[LOOP_BIT] ? q.rx_word
                        : pcm_encode(tx_sample_sign, tx_sample_mag);
                d.out = d.tx_sr[SIGN_BIT];
                d.oe = (link.control_address_select != CA_HIGH);
                if (link.control_address_select == CA_NEG) begin
                    // steady level on the control input: high runs, low powers down
                    d.steady_pd = ~link.control_serial_in;
                end
            end else if (q.active && q.cnt < CNT_W'(PCM_BITS)) begin
                d.tx_sr = {q.tx_sr[6:0], 1'b0};
                d.out = q.tx_sr[SIGN_BIT - 1];
            end else begin
                // eighth bit done: sync held low too long is ignored
                d.active = 1'b0;
                d.oe = 1'b0;
            end
        end
        if (fall && q.active && q.cnt < CNT_W'(PCM_BITS)) begin
            d.cnt = q.cnt + 1'b1;
            if (q.ca != CA_HIGH) begin
                d.rx_sr = {q.rx_sr[6:0], link.pcm_serial_in};
            end
            if (q.ca != CA_NEG) begin
                d.ctl_sr = {q.ctl_sr[6:0], link.control_serial_in};
            end
            if (q.cnt == CNT_W'(PCM_BITS - 1)) begin
                if (q.ca != CA_HIGH) begin
                    d.rx_word = {q.rx_sr[6:0], link.pcm_serial_in};
                    d.rx_valid = 1'b1;
                end
                // temp register lands only when complete, so a cut word is dropped
                if (q.ca == CA_LOW) begin
                    d.reg_a = {q.ctl_sr[6:0], link.control_serial_in};
                end else if (q.ca == CA_HIGH) begin
                    d.reg_b = {q.ctl_sr[6:0], link.control_serial_in};
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{mclk: 1'b0, armed: 1'b0, active: 1'b0, cnt: '0, ca: CA_HIGH,
                   tx_sr: 8'h00, rx_sr: 8'h00, ctl_sr: 8'h00, reg_a: CTL_A_RESET,
                   reg_b: CTL_B_RESET, steady_pd: 1'b0, out: 1'b0, oe: 1'b0,
                   rx_word: 8'h00, rx_valid: 1'b0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, each a flip-flop bit of the state except power_down, an or of two state bits
    assign link.pcm_serial_out = q.out;
    assign link.pcm_out_oe = q.oe;
    assign link.push_pull_drive_outputs = q.reg_b[PP_LSB +: PP_W];
    assign link.analog_ground_drain_oe = q.reg_b[OD_ANA_BIT];
    assign link.digital_ground_drain_oe = q.reg_b[OD_DIG_LSB +: OD_DIG_W];
    assign rx_pcm_word = q.rx_word;
    assign rx_pcm_valid = q.rx_valid;
    assign tx_gain = q.reg_a[TXG_LSB +: GAIN_W];
    assign rx_gain = q.reg_a[RXG_LSB +: GAIN_W];
    assign loopback = q.reg_a[LOOP_BIT];
    assign chip_test = q.reg_a[TEST_BIT];
    // either a control word or the steady low level can power down
    assign power_down = q.reg_b[PD_BIT] | q.steady_pd;

endmodule

// ===== design/codec_link_master.sv
/*
 * Host end: switching-system controller that clocks, frames and feeds the codec.
 * Software reaches it over axi4-lite; one transfer runs per start command.
 */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module codec_link_master
    import pcm_codec_pkg::*;
#(
    parameter int HALF_PERIOD = MCLK_HALF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    codec_link_if.host link
);

    typedef enum logic [1:0] {IDLE, ARM, XFER} xfer_state_t;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic mclk;
        logic sync_n;
        xfer_state_t st;
        logic [CNT_W-1:0] cnt;
        ca_level_t ca;
        logic lvl;
        logic [7:0] pcm_tx;
        logic [7:0] ctl_tx;
        logic [7:0] tx_sr;
        logic [7:0] ctl_sr;
        logic [7:0] rx_sr;
        logic [7:0] rx_word;
        logic pcm_o;
        logic ctl_o;
        logic [AXI_AW-1:0] awaddr;
        logic aw_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } host_state_t;

    host_state_t q;
    host_state_t d;
    logic tick;
    logic rise;
    logic fall;

    // free-running master clock from a divider, never gated by frames
    assign tick = (q.div == DIV_W'(HALF_PERIOD - 1));
    assign rise = tick & ~q.mclk;
    assign fall = tick & q.mclk;

    always_comb begin
        d = q;
        d.div = tick ? '0 : q.div + 1'b1;
        if (tick) begin
            d.mclk = ~q.mclk;
        end
        ////////////////////////////////////////////////////////////////////////////
        // axi4-lite slave, address and data in either order
        if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (q.awaddr == REG_CTRL && q.wstrb[0]) begin
                d.ca = ca_level_t'(q.wdata[CTRL_CA_LSB +: 2]);
                d.lvl = q.wdata[CTRL_LVL];
                if (q.wdata[CTRL_START] && q.st == IDLE) begin
                    d.st = ARM;
                end
            end else if (q.awaddr == REG_DATA) begin
                if (q.wstrb[0]) begin
                    d.pcm_tx = q.wdata[7:0];
                end
                if (q.wstrb[1]) begin
                    d.ctl_tx = q.wdata[DATA_CTL_LSB +: 8];
                end
            end else if (q.awaddr != REG_STAT && q.awaddr != REG_DRIVE) begin
                d.bresp = RESP_SLVERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL: d.rdata = 32'({q.lvl, q.ca, 1'b0});
                REG_DATA: d.rdata = 32'({q.ctl_tx, q.pcm_tx});
                REG_STAT: d.rdata = 32'({q.st != IDLE, q.rx_word});
                REG_DRIVE: d.rdata = 32'({link.digital_ground_drain_outputs,
                                          link.analog_ground_drain_output,
                                          link.push_pull_drive_outputs});
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        ////////////////////////////////////////////////////////////////////////////
        // frame: sync falls on a falling edge, bits launch on rising edges
        case (q.st)
            IDLE: begin
                d.ctl_o = q.lvl;
            end
            ARM: begin
                if (fall) begin
                    d.sync_n = 1'b0;
                    d.cnt = '0;
                    d.tx_sr = q.pcm_tx;
                    d.ctl_sr = q.ctl_tx;
                    d.st = XFER;
                end
            end
            XFER: begin
                if (rise) begin
                    d.pcm_o = q.tx_sr[SIGN_BIT];
                    d.ctl_o = (q.ca == CA_NEG) ? q.lvl : q.ctl_sr[SIGN_BIT];
                    d.tx_sr = {q.tx_sr[6:0], 1'b0};
                    d.ctl_sr = {q.ctl_sr[6:0], 1'b0};
                end
                if (fall) begin
                    d.cnt = q.cnt + 1'b1;
                    d.rx_sr = {q.rx_sr[6:0], link.pcm_bus};
                    if (q.cnt == CNT_W'(PCM_BITS - 1)) begin
                        d.sync_n = 1'b1;
                        d.rx_word = {q.rx_sr[6:0], link.pcm_bus};
                        d.st = IDLE;
                    end
                end
            end
            default: d.st = IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{div: '0, mclk: 1'b0, sync_n: 1'b1, st: IDLE, cnt: '0, ca: CA_NEG,
                   lvl: 1'b1, pcm_tx: 8'h00, ctl_tx: 8'h00, tx_sr: 8'h00,
                   ctl_sr: 8'h00, rx_sr: 8'h00, rx_word: 8'h00, pcm_o: 1'b0,
                   ctl_o: 1'b1, awaddr: '0, aw_got: 1'b0, wdata: 32'h0000_0000,
                   wstrb: 4'h0, w_got: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY,
                   rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY};
        end else begin
            q <= d;
        end
    end

    assign link.master_clock_in = q.mclk;
    assign link.frame_sync_n = q.sync_n;
    assign link.control_address_select = q.ca;
    assign link.control_serial_in = q.ctl_o;
    assign link.pcm_serial_in = q.pcm_o;
    assign s_axi_awready = ~q.aw_got & ~q.bvalid;
    assign s_axi_wready = ~q.w_got & ~q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

endmodule

// ===== sim/codec_link_properties.sv
/*
 * Link checker: properties on the codec serial link.
 * Assumes the host's HALF_PERIOD.
 */
`timescale 1ns/1ns
module codec_link_properties
    import pcm_codec_pkg::*;
#(
    parameter int HALF_PERIOD = MCLK_HALF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic master_clock_in,
    input wire logic frame_sync_n,
    input wire ca_level_t control_address_select,
    input wire logic control_serial_in,
    input wire logic pcm_serial_in,
    input wire logic pcm_serial_out,
    input wire logic pcm_out_oe,
    input wire logic [2:0] push_pull_drive_outputs,
    input wire logic analog_ground_drain_oe,
    input wire logic [1:0] digital_ground_drain_oe
);
    // eight master periods per word, slack for edge detection
    localparam int OE_MAX = 16 * HALF_PERIOD + 4;
    localparam int REL_MAX = HALF_PERIOD + 3;
    logic [9:0] oe_cnt_q;
    logic [9:0] hi_cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_cnt_q <= '0;
            hi_cnt_q <= '0;
        end else begin
            oe_cnt_q <= pcm_out_oe ? oe_cnt_q + 10'h1 : 10'h0;
            hi_cnt_q <= (!frame_sync_n || hi_cnt_q == 10'h3ff) ? {10{frame_sync_n}} & hi_cnt_q
                : hi_cnt_q + 10'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_oe_start;
        $rose(pcm_out_oe);
    endsequence
    sequence s_sync_drop;
        $fell(frame_sync_n);
    endsequence

    property p_oe_needs_sync;
        s_oe_start |-> !frame_sync_n && master_clock_in;
    endproperty
    a_oe_needs_sync: assert property (p_oe_needs_sync)
        else $error("pcm drive began outside a frame rise");
    property p_no_pcm_high;
        pcm_out_oe |-> control_address_select != CA_HIGH;
    endproperty
    a_no_pcm_high: assert property (p_no_pcm_high)
        else $error("pcm driven with control address high");
    property p_out_stable;
        pcm_out_oe && $past(pcm_out_oe) && !master_clock_in |-> $stable(pcm_serial_out);
    endproperty
    a_out_stable: assert property (p_out_stable)
        else $error("pcm out changed while master clock low");
    property p_oe_len;
        oe_cnt_q <= OE_MAX;
    endproperty
    a_oe_len: assert property (p_oe_len)
        else $error("pcm drive held past one word");
    property p_oe_release;
        hi_cnt_q > REL_MAX |-> !pcm_out_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("pcm drive not released after sync returned high");
    property p_drive_change;
        $changed({push_pull_drive_outputs, analog_ground_drain_oe, digital_ground_drain_oe})
            |-> control_address_select == CA_HIGH;
    endproperty
    a_drive_change: assert property (p_drive_change)
        else $error("drive outputs changed without a register B word");
    property p_in_stable;
        !frame_sync_n && master_clock_in && $past(master_clock_in, 2)
            |-> $stable({pcm_serial_in, control_serial_in});
    endproperty
    a_in_stable: assert property (p_in_stable)
        else $error("host input bit changed near the capture edge");
    property p_sync_at_fall;
        s_sync_drop |-> !master_clock_in;
    endproperty
    a_sync_at_fall: assert property (p_sync_at_fall)
        else $error("frame sync fell while master clock high");
endmodule

// ===== sim/tb_top.sv
/*
 * Bench: host controller and codec serial port joined by the link interface.
 * Assumes package and design compiled first; the bench is the AXI4-Lite master.
 */
`timescale 1ns/1ns
module tb_top;
    import pcm_codec_pkg::*;

    localparam int HALF = 6;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, tx_sign, rx_valid, loopback, chip_test, power_down;
    logic [7:0] awaddr, araddr, rx_word;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [11:0] tx_mag;
    logic [2:0] tx_gain, rx_gain;
    int err_total, n_compared, cycles, rx_seen;

    codec_link_if codec_link_if_inst();
    codec_serial_port #(.SAMPLE_W(12)) codec_serial_port_inst (.aclk(aclk), .aresetn(aresetn),
        .link(codec_link_if_inst), .tx_sample_sign(tx_sign), .tx_sample_mag(tx_mag),
        .rx_pcm_word(rx_word), .rx_pcm_valid(rx_valid), .tx_gain(tx_gain), .rx_gain(rx_gain),
        .loopback(loopback), .chip_test(chip_test), .power_down(power_down));
    codec_link_master #(.HALF_PERIOD(HALF)) codec_link_master_inst (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link(codec_link_if_inst));
    codec_link_properties #(.HALF_PERIOD(HALF)) codec_link_properties_inst (.aclk(aclk),
        .aresetn(aresetn), .master_clock_in(codec_link_if_inst.master_clock_in),
        .frame_sync_n(codec_link_if_inst.frame_sync_n),
        .control_address_select(codec_link_if_inst.control_address_select),
        .control_serial_in(codec_link_if_inst.control_serial_in),
        .pcm_serial_in(codec_link_if_inst.pcm_serial_in),
        .pcm_serial_out(codec_link_if_inst.pcm_serial_out),
        .pcm_out_oe(codec_link_if_inst.pcm_out_oe),
        .push_pull_drive_outputs(codec_link_if_inst.push_pull_drive_outputs),
        .analog_ground_drain_oe(codec_link_if_inst.analog_ground_drain_oe),
        .digital_ground_drain_oe(codec_link_if_inst.digital_ground_drain_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // called just after a rising edge; bready and rready stay high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            r = bresp;
        end while (!bvalid);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            d = rdata;
            r = rresp;
        end while (!rvalid);
    endtask

    task automatic frame(input ca_level_t ca, input logic lvl, input logic [7:0] ctl,
                         input logic [7:0] pcm);
        logic [31:0] d;
        logic [1:0] r;
        wr(REG_DATA, {16'h0, ctl, pcm}, r);
        wr(REG_CTRL, {28'h0, lvl, ca, 1'b1}, r);
        d = 32'h100;
        while (d[STAT_BUSY]) rd(REG_STAT, d, r);
        // device load lags busy
        repeat (4) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        logic [31:0] d;
        logic [1:0] r;
        rd(REG_DRIVE, d, r);
        chk_word("drive levels", 32'h38, d);
        chk_word("pcm bus idle", 32'h1, {31'h0, codec_link_if_inst.pcm_bus});
        rd(8'h10, d, r);
        chk_resp("unmapped read", RESP_SLVERR, r);
        wr(8'h10, 32'hff, r);
        chk_resp("unmapped write", RESP_SLVERR, r);
    endtask

    task automatic t_reg_a();
        logic [31:0] d;
        logic [1:0] r;
        tx_sign <= 1'b1;
        tx_mag <= 12'h01b;
        frame(CA_LOW, 1'b0, 8'h9d, 8'h5a);
        rd(REG_STAT, d, r);
        chk_word("encoded word", 32'h9b, {24'h0, d[7:0]});
        chk_word("received word", 32'h5a, {24'h0, rx_word});
        chk_word("gains", 32'h1d, {26'h0, rx_gain, tx_gain});
        chk_word("test loop", 32'h2, {30'h0, chip_test, loopback});
        chk_word("valid pulses", 32'h1, rx_seen);
    endtask

    task automatic t_loopback();
        logic [31:0] d;
        logic [1:0] r;
        tx_sign <= 1'b0;
        tx_mag <= 12'h00c;
        frame(CA_LOW, 1'b0, 8'h40, 8'h3c);
        rd(REG_STAT, d, r);
        chk_word("word before loop", 32'h0c, {24'h0, d[7:0]});
        chk_word("loop set", 32'h1, {31'h0, loopback});
        frame(CA_LOW, 1'b0, 8'h00, 8'h11);
        rd(REG_STAT, d, r);
        chk_word("looped word", 32'h3c, {24'h0, d[7:0]});
        chk_word("received word", 32'h11, {24'h0, rx_word});
    endtask

    task automatic t_reg_b();
        logic [31:0] d;
        logic [1:0] r;
        frame(CA_HIGH, 1'b0, 8'h3d, 8'hff);
        rd(REG_DRIVE, d, r);
        chk_word("drive levels", 32'h05, d);
        chk_word("push pull", 32'h5, {29'h0, codec_link_if_inst.push_pull_drive_outputs});
        chk_word("no pcm capture", 32'h11, {24'h0, rx_word});
        chk_word("valid pulses", 32'h3, rx_seen);
    endtask

    task automatic t_steady();
        frame(CA_NEG, 1'b0, 8'h00, 8'h77);
        chk_word("power down", 32'h1, {31'h0, power_down});
        chk_word("received word", 32'h77, {24'h0, rx_word});
        frame(CA_NEG, 1'b1, 8'h00, 8'h78);
        chk_word("power up", 32'h0, {31'h0, power_down});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (rx_valid === 1'b1) rx_seen++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, tx_sign} = '0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata, tx_mag} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_state();
        t_reg_a();
        t_loopback();
        t_reg_b();
        t_steady();
        test_done();
    end
endmodule
